// [src/tec8_timer.sv]
// Top of the 8-bit timer/event counter with its port 2 pin control
`timescale 1ns/10ps
module tec8_timer #(
    parameter int PIN_COUNT = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register access
    input wire logic [15:0] addr_in,
    input wire logic wr_en_in,
    input wire logic [7:0] wr_data_in,
    input wire logic rd_en_in,
    output logic [7:0] rd_data_out,
    // Port 2 pins
    input wire logic [PIN_COUNT-1:0] port2_pin_in,
    output logic [PIN_COUNT-1:0] port2_pin_out,
    output logic [PIN_COUNT-1:0] port2_pin_oe_out,
    // Timer event
    output logic match_interrupt_request_out
);
    // -------------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------------
    logic [PIN_COUNT-1:0] port2_direction;
    logic [PIN_COUNT-1:0] port2_latch;
    logic [7:0] timer_mode_control;
    logic [7:0] compare_value;
    logic [PIN_COUNT-1:0] next_port2_direction;
    logic [PIN_COUNT-1:0] next_port2_latch;
    logic [7:0] next_timer_mode_control;
    logic [7:0] next_compare_value;
    logic [7:0] next_rd_data;

    // Counting state
    localparam int PRESCALE_CNT_W = tec8_pkg::PRESCALE_BITS;
    logic [7:0] count_value;
    logic [PRESCALE_CNT_W-1:0] prescale_count;
    logic event_level_prev;
    logic timer_output;
    logic [7:0] next_count_value;
    logic [PRESCALE_CNT_W-1:0] next_prescale_count;
    logic next_timer_output;
    logic next_match_request;
    logic [PIN_COUNT-1:0] next_pin_out;
    logic [PIN_COUNT-1:0] next_pin_oe;

    // Decoded controls
    logic count_enable;
    logic pwm_mode;
    logic output_enable;
    logic [1:0] clock_select;
    logic event_level;
    logic count_tick;
    logic compare_match;
    logic counter_wrap;

    // -------------------------------------------------------------------------
    // External event input
    // -------------------------------------------------------------------------
    tec8_input_sync u_event_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pin_in(port2_pin_in[tec8_pkg::SHARED_PIN]),
        .level_out(event_level)
    );

    assign count_enable = timer_mode_control[tec8_pkg::MODE_COUNT_ENABLE_BIT];
    assign pwm_mode = timer_mode_control[tec8_pkg::MODE_PWM_BIT];
    assign output_enable = timer_mode_control[tec8_pkg::MODE_OUTPUT_ENABLE_BIT];
    assign clock_select = {timer_mode_control[tec8_pkg::MODE_CLOCK_SELECT_HIGH],
                           timer_mode_control[tec8_pkg::MODE_CLOCK_SELECT_LOW]};

    // -------------------------------------------------------------------------
    // Register writes and reads
    // -------------------------------------------------------------------------
    always_comb begin
        next_port2_direction = port2_direction;
        next_port2_latch = port2_latch;
        next_timer_mode_control = timer_mode_control;
        next_compare_value = compare_value;
        next_rd_data = rd_data_out;
        if (wr_en_in) begin
            if (addr_in == tec8_pkg::ADDR_PORT2_DIRECTION) begin
                next_port2_direction = wr_data_in[PIN_COUNT-1:0];
            end else if (addr_in == tec8_pkg::ADDR_PORT2_LATCH) begin
                next_port2_latch = wr_data_in[PIN_COUNT-1:0];
            end else if (addr_in == tec8_pkg::ADDR_TIMER_MODE_CONTROL) begin
                next_timer_mode_control = wr_data_in & tec8_pkg::MODE_WRITABLE_MASK;
            end else if (addr_in == tec8_pkg::ADDR_COMPARE_VALUE) begin
                next_compare_value = wr_data_in;
            end
        end
        if (rd_en_in) begin
            if (addr_in == tec8_pkg::ADDR_PORT2_DIRECTION) begin
                next_rd_data = port2_direction;
            end else if (addr_in == tec8_pkg::ADDR_PORT2_LATCH) begin
                next_rd_data = port2_latch;
            end else if (addr_in == tec8_pkg::ADDR_TIMER_MODE_CONTROL) begin
                next_rd_data = timer_mode_control;
            end else if (addr_in == tec8_pkg::ADDR_COMPARE_VALUE) begin
                next_rd_data = compare_value;
            end else if (addr_in == tec8_pkg::ADDR_COUNT_VALUE) begin
                next_rd_data = count_value;
            end else begin
                next_rd_data = tec8_pkg::READ_UNMAPPED;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            port2_direction <= tec8_pkg::RST_PORT2_DIRECTION;
            port2_latch <= tec8_pkg::RST_PORT2_LATCH;
            timer_mode_control <= tec8_pkg::RST_TIMER_MODE_CONTROL;
            compare_value <= tec8_pkg::RST_COMPARE_VALUE;
            rd_data_out <= tec8_pkg::READ_UNMAPPED;
        end else begin
            port2_direction <= next_port2_direction;
            port2_latch <= next_port2_latch;
            timer_mode_control <= next_timer_mode_control;
            compare_value <= next_compare_value;
            rd_data_out <= next_rd_data;
        end
    end

    // -------------------------------------------------------------------------
    // Count clock selection
    // -------------------------------------------------------------------------
    always_comb begin
        count_tick = 1'b0;
        case (clock_select)
            tec8_pkg::CLK_SEL_SYSTEM: begin
                count_tick = 1'b1;
            end
            tec8_pkg::CLK_SEL_DIV256: begin
                count_tick = &prescale_count;
            end
            tec8_pkg::CLK_SEL_RISING: begin
                count_tick = event_level & ~event_level_prev;
            end
            default: begin
                count_tick = ~event_level & event_level_prev;
            end
        endcase
        if (!count_enable) begin
            count_tick = 1'b0;
        end
    end

    assign compare_match = count_tick && (count_value == compare_value);
    assign counter_wrap = count_tick && (count_value == tec8_pkg::COUNT_WRAP);

    // -------------------------------------------------------------------------
    // Counter, match and timer output
    // -------------------------------------------------------------------------
    always_comb begin
        next_prescale_count = prescale_count + 1'b1;
        next_count_value = count_value;
        next_timer_output = timer_output;
        next_match_request = compare_match;
        if (!count_enable) begin
            next_prescale_count = '0;
            next_count_value = tec8_pkg::RST_COUNT_VALUE;
            next_timer_output = 1'b0;
        end else if (count_tick) begin
            if (compare_match && !pwm_mode) begin
                next_count_value = tec8_pkg::RST_COUNT_VALUE;
            end else begin
                next_count_value = count_value + 1'b1;
            end
            if (pwm_mode) begin
                if (compare_match) begin
                    next_timer_output = 1'b0;
                end else if (counter_wrap) begin
                    next_timer_output = 1'b1;
                end
            end else if (compare_match) begin
                next_timer_output = ~timer_output;
            end
        end
        if (!output_enable) begin
            next_timer_output = 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prescale_count <= '0;
            count_value <= tec8_pkg::RST_COUNT_VALUE;
            timer_output <= 1'b0;
            event_level_prev <= 1'b0;
            match_interrupt_request_out <= 1'b0;
        end else begin
            prescale_count <= next_prescale_count;
            count_value <= next_count_value;
            timer_output <= next_timer_output;
            event_level_prev <= event_level;
            match_interrupt_request_out <= next_match_request;
        end
    end

    // -------------------------------------------------------------------------
    // Port 2 pin drivers
    // -------------------------------------------------------------------------
    genvar pin;
    generate
        for (pin = 0; pin < PIN_COUNT; pin = pin + 1) begin : g_pin
            always_comb begin
                next_pin_oe[pin] = ~port2_direction[pin];
                next_pin_out[pin] = port2_latch[pin];
                if (pin == tec8_pkg::SHARED_PIN && output_enable) begin
                    next_pin_out[pin] = timer_output | port2_latch[pin];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            port2_pin_out <= '0;
            port2_pin_oe_out <= '0;
        end else begin
            port2_pin_out <= next_pin_out;
            port2_pin_oe_out <= next_pin_oe;
        end
    end
endmodule

// [src/tec8_pkg.sv]
// Constants shared by the 8-bit timer/event counter block
// -----------------------------------------------------------------------------
// Overview of operation
// - Direction bit 0 drives the pin, 1 releases it; reset loads all ones.
// - Interval mode: match clears counter, counting goes on, interrupt request pulses.
// - Match period is compare value plus one count clocks, 00H to FFH.
// - Count step is one clock, 256 clocks, or one external edge period.
// - Event mode counts each valid input edge; low select bit picks the polarity.
// - Square-wave mode inverts the pin on match, clears counter, raises request.
// - Clearing count enable forces the square-wave output low.
// - Timer output starts low when output enable is set, square-wave and PWM.
// - PWM mode match does not clear counter; request still pulses.
// - Compare rewrite while counting may match at once; software stops first.
// - PWM compare rewrite while counting may hold the output high a period.
// - Clock select 00 clock, 01 clock/256, 10 rising input, 11 falling input.
// - Mode control: enable bit 7, PWM bit 6, select, output enable bit 0.
// -----------------------------------------------------------------------------
package tec8_pkg;
    // -------------------------------------------------------------------------
    // Register addresses
    // -------------------------------------------------------------------------
    localparam logic [15:0] ADDR_PORT2_DIRECTION = 16'hFF22;
    localparam logic [15:0] ADDR_TIMER_MODE_CONTROL = 16'hFF53;
    localparam logic [15:0] ADDR_PORT2_LATCH = 16'hFF02;
    localparam logic [15:0] ADDR_COMPARE_VALUE = 16'hFF50;
    localparam logic [15:0] ADDR_COUNT_VALUE = 16'hFF51;
    // -------------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------------
    localparam logic [7:0] RST_PORT2_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_TIMER_MODE_CONTROL = 8'h00;
    localparam logic [7:0] RST_PORT2_LATCH = 8'h00;
    localparam logic [7:0] RST_COMPARE_VALUE = 8'h00;
    localparam logic [7:0] RST_COUNT_VALUE = 8'h00;
    localparam logic [7:0] COUNT_WRAP = 8'hFF;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    // -------------------------------------------------------------------------
    // Mode control fields
    // -------------------------------------------------------------------------
    localparam int MODE_COUNT_ENABLE_BIT = 7;
    localparam int MODE_PWM_BIT = 6;
    localparam int MODE_CLOCK_SELECT_HIGH = 2;
    localparam int MODE_CLOCK_SELECT_LOW = 1;
    localparam int MODE_OUTPUT_ENABLE_BIT = 0;
    localparam logic [7:0] MODE_WRITABLE_MASK = 8'hC7;
    localparam int SHARED_PIN = 7;
    // -------------------------------------------------------------------------
    // Clock select codes and prescaler
    // -------------------------------------------------------------------------
    localparam logic [1:0] CLK_SEL_SYSTEM = 2'h0;
    localparam logic [1:0] CLK_SEL_DIV256 = 2'h1;
    localparam logic [1:0] CLK_SEL_RISING = 2'h2;
    localparam logic [1:0] CLK_SEL_FALLING = 2'h3;
    localparam int PRESCALE_BITS = 8;
endpackage

// [src/tec8_input_sync.sv]
// Three-flop input synchroniser with agreement filter
`timescale 1ns/10ps
module tec8_input_sync (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Pin side
    input wire logic pin_in,
    // Filtered level
    output logic level_out
);
    logic stage1;
    logic stage2;
    logic stage3;
    logic next_level;

    always_comb begin
        next_level = level_out;
        if (stage2 == stage3) begin
            next_level = stage3;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level_out <= 1'b0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level_out <= next_level;
        end
    end
endmodule

// [tb/tec8_timer_monitor.sv]
// Port checker of the 8-bit timer/event counter
`timescale 1ns/10ps
module tec8_timer_monitor #(
    parameter int PIN_COUNT = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register access
    input wire logic [15:0] addr_in,
    input wire logic wr_en_in,
    input wire logic [7:0] wr_data_in,
    input wire logic rd_en_in,
    input wire logic [7:0] rd_data_out,
    // Pins and event
    input wire logic [PIN_COUNT-1:0] port2_pin_in,
    input wire logic [PIN_COUNT-1:0] port2_pin_out,
    input wire logic [PIN_COUNT-1:0] port2_pin_oe_out,
    input wire logic match_interrupt_request_out
);
    logic [7:0] dir_m, mode_m, cmp_m;
    logic [15:0] gap;
    logic chg, lat7;
    wire logic irq = match_interrupt_request_out;
    wire logic [15:0] per = mode_m[1] ? {cmp_m, 8'h00} + 16'h0100 : {8'h00, cmp_m} + 16'h0001;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dir_m <= 8'hFF;
            mode_m <= 8'h00;
            cmp_m <= 8'h00;
            lat7 <= 1'b0;
            gap <= 16'h0000;
            chg <= 1'b1;
        end else begin
            if (wr_en_in && addr_in == 16'hFF22) dir_m <= wr_data_in;
            if (wr_en_in && addr_in == 16'hFF53) mode_m <= wr_data_in & 8'hC7;
            if (wr_en_in && addr_in == 16'hFF50) cmp_m <= wr_data_in;
            if (wr_en_in && addr_in == 16'hFF02) lat7 <= wr_data_in[7];
            gap <= irq ? 16'h0001 : (gap == 16'hFFFF ? gap : gap + 16'h0001);
            chg <= (wr_en_in && addr_in inside {16'hFF53, 16'hFF50}) ? 1'b1 : (irq ? 1'b0 : chg);
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    oe_track_a: assert property (port2_pin_oe_out == ~$past(dir_m))
        else $error("drive enable wrong");
    dir_read_a: assert property (rd_en_in && addr_in == 16'hFF22 |=> rd_data_out == $past(dir_m))
        else $error("direction readback wrong");
    mode_read_a: assert property (rd_en_in && addr_in == 16'hFF53 |=> rd_data_out == $past(mode_m))
        else $error("mode readback wrong");
    unmapped_read_a: assert property (rd_en_in && !(addr_in inside {16'hFF22, 16'hFF53, 16'hFF02, 16'hFF50,
        16'hFF51}) |=> rd_data_out == 8'h00)
        else $error("unmapped read not zero");
    idle_quiet_a: assert property (!mode_m[7] && !$past(mode_m[7]) |-> !irq)
        else $error("request while stopped");
    match_period_a: assert property (irq && mode_m[7:6] == 2'b10 && !mode_m[2] && !chg |-> gap == per)
        else $error("match period wrong");
    pwm_period_a: assert property (irq && mode_m[7:6] == 2'b11 && mode_m[2:1] == 2'b00 && !chg
        |-> gap == 16'h0100)
        else $error("pwm period wrong");
    stop_low_a: assert property ($fell(mode_m[7]) && !lat7 |-> ##3 !port2_pin_out[7])
        else $error("output not low after stop");
    cover property (irq && mode_m[7:6] == 2'b10 && !mode_m[2]);
    cover property (irq && mode_m[2]);
    cover property (irq && mode_m[6]);
endmodule
bind tec8_timer tec8_timer_monitor #(.PIN_COUNT(PIN_COUNT)) u_mon (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_en_in(wr_en_in), .wr_data_in(wr_data_in),
    .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .port2_pin_in(port2_pin_in), .port2_pin_out(port2_pin_out),
    .port2_pin_oe_out(port2_pin_oe_out), .match_interrupt_request_out(match_interrupt_request_out));

// [tb/tec8_pin_partner.sv]
// Event pulse source and pin load on port 2
`timescale 1ns/10ps
module tec8_pin_partner (
    // Clock
    input wire logic clk_in,
    // Pulse control
    input wire logic go_in,
    input wire logic inv_in,
    input wire logic [3:0] width_in,
    // Port side
    input wire logic [7:0] pin_drv_in,
    input wire logic [7:0] pin_oe_in,
    output logic [7:0] pin_lvl_out
);
    logic [4:0] cnt = 5'h00;
    logic ev;
    always_ff @(posedge clk_in) begin
        if (go_in)
            cnt <= {width_in, 1'b0};
        else if (cnt != 5'h00)
            cnt <= cnt - 5'h01;
    end
    assign ev = (cnt > {1'b0, width_in}) ^ inv_in;
    // Released pins float high, pin 7 carries pulses while the design listens
    assign pin_lvl_out = (pin_drv_in & pin_oe_in) | (~pin_oe_in & {ev, 7'h7F});
endmodule

// [tb/tec8_timer_tb.sv]
// Self-checking bench of the 8-bit timer/event counter
`timescale 1ns/10ps
module tec8_timer_tb;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [15:0] addr_in = 16'h0000;
    logic wr_en_in = 1'b0;
    logic rd_en_in = 1'b0;
    logic [7:0] wr_data_in = 8'h00;
    logic [7:0] rd_data, pin_out, pin_oe, pin_lvl, v;
    logic irq, go = 1'b0, inv = 1'b0;
    logic [3:0] wid = 4'h3;
    logic [1:0] s;
    int num_errors = 0;
    int n_tests = 0;
    int irq_cnt = 0;
    int gap, n, hi;
    always #20 clk_in = ~clk_in;
    always @(posedge clk_in) if (irq === 1'b1) irq_cnt++;
    tec8_timer #(.PIN_COUNT(8)) DUT (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_en_in(wr_en_in),
        .wr_data_in(wr_data_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data), .port2_pin_in(pin_lvl),
        .port2_pin_out(pin_out), .port2_pin_oe_out(pin_oe), .match_interrupt_request_out(irq));
    tec8_pin_partner u_pins (.clk_in(clk_in), .go_in(go), .inv_in(inv), .width_in(wid), .pin_drv_in(pin_out),
        .pin_oe_in(pin_oe), .pin_lvl_out(pin_lvl));
    task automatic stop_test();
        if (num_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_in) #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cyc(1);
        addr_in = a;
        wr_data_in = d;
        wr_en_in = 1'b1;
        cyc(1);
        wr_en_in = 1'b0;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
        cyc(1);
        addr_in = a;
        rd_en_in = 1'b1;
        cyc(1);
        rd_en_in = 1'b0;
        chk({8'h00, rd_data}, {8'h00, exp});
    endtask
    task automatic wait_irq(output int c);
        c = 0;
        do begin
            cyc(1);
            c++;
            if (c > 3000) begin
                num_errors++;
                stop_test();
            end
        end while (irq !== 1'b1);
    endtask
    task automatic pulse(input int k);
        repeat (k) begin
            go = 1'b1;
            cyc(1);
            go = 1'b0;
            cyc(2 * wid + 8);
        end
    endtask
    function automatic int period(input logic [1:0] sel, input int cmp);
        return (cmp + 1) * (sel == 2'h1 ? 256 : 1);
    endfunction
    initial begin
        n = $urandom(32'h5dd9);
        repeat (2) @(posedge clk_in);
        #1 rst_in = 1'b0;
        chk(pin_oe, 16'h0000);
        rdchk(16'hFF22, 8'hFF);
        rdchk(16'hFF53, 8'h00);
        v = 8'($urandom);
        wr(16'hFF53, v);
        rdchk(16'hFF53, v & 8'hC7);
        wr(16'hFF53, 8'h00);
        wr(16'hFF51, 8'h5A);
        rdchk(16'hFF51, 8'h00);
        rdchk({8'h10, 8'($urandom)}, 8'h00);
        v = 8'($urandom);
        wr(16'hFF22, v);
        cyc(2);
        chk(pin_oe, {8'h00, ~v});
        for (int i = 0; i < 4; i++) begin
            s = (i == 3) ? 2'h1 : 2'h0;
            n = (i == 0) ? 0 : (i == 1) ? 255 : (i == 2) ? $urandom_range(1, 30) : 1;
            wr(16'hFF53, 8'h00);
            wr(16'hFF53, {5'h00, s, 1'b0});
            wr(16'hFF50, 8'(n));
            wr(16'hFF53, {5'h10, s, 1'b0});
            wait_irq(gap);
            wait_irq(gap);
            chk(16'(gap), 16'(period(s, n)));
        end
        wr(16'hFF22, 8'hFF);
        for (int e = 0; e < 2; e++) begin
            inv = e[0];
            wid = 4'($urandom_range(2, 15));
            wr(16'hFF53, 8'h00);
            wr(16'hFF53, {5'h00, 1'b1, e[0], 1'b0});
            wr(16'hFF50, 8'h03);
            wr(16'hFF53, {5'h10, 1'b1, e[0], 1'b0});
            irq_cnt = 0;
            pulse(2);
            rdchk(16'hFF51, 8'h02);
            pulse(2);
            chk(16'(irq_cnt), 16'h0001);
            rdchk(16'hFF51, 8'h00);
        end
        wr(16'hFF22, 8'h7F);
        wr(16'hFF02, 8'h00);
        wr(16'hFF53, 8'h00);
        wr(16'hFF53, 8'h01);
        wr(16'hFF50, 8'h14);
        wr(16'hFF53, 8'h81);
        chk(pin_out[7], 16'h0000);
        wait_irq(gap);
        cyc(3);
        chk(pin_out[7], 16'h0001);
        wr(16'hFF53, 8'h01);
        cyc(3);
        chk(pin_out[7], 16'h0000);
        wr(16'hFF53, 8'h41);
        wr(16'hFF50, 8'h40);
        wr(16'hFF53, 8'hC1);
        chk(pin_out[7], 16'h0000);
        wait_irq(gap);
        wait_irq(gap);
        chk(16'(gap), 16'h0100);
        hi = 0;
        repeat (256) begin
            cyc(1);
            hi += pin_out[7];
        end
        chk(16'(hi), 16'h0041);
        stop_test();
    end
endmodule
